// [logic/hdlc_chan_regs.svh]
// Register offsets, field positions and reset values of the channel parameter bank
`ifndef HDLC_CHAN_REGS_SVH
`define HDLC_CHAN_REGS_SVH

// Per-channel pair: byte address = channel * 8 + register offset * 4
`define CHAN_REGION_TOP   4'h0
`define EVENT_ENABLE_OFS  1'b0
`define RX_STATE_OFS      1'b1

// Shared interrupt registers
`define IRQ_STATUS_ADDR   12'h100
`define IRQ_CLEAR_ADDR    12'h104
`define IRQ_ENABLE_ADDR   12'h108

// Event positions, bit 0 being the least significant bit
`define EV_LINE_ACTIVE    13
`define EV_QUIET_LINE     12
`define EV_OVERSIZE_FRAME 5
`define EV_TX_STARVED     4
`define EV_RX_FRAME       3
`define EV_NO_BUFFER      2
`define EV_TX_BUFFER      1
`define EV_RX_BUFFER      0
`define EV_DEFINED_MASK   16'h303f
`define EV_ENABLE_RESET   16'h0000

// Interrupt table entry
`define ENTRY_VALID_BIT   15
`define ENTRY_WRAP_BIT    14
`define ENTRY_CHAN_LSB    6

// Receive state word high byte
`define RX_FIXED_ONE_BIT  29
`define RX_BIG_ENDIAN_BIT 28
`define RX_CODE_MSB       27
`define RX_CODE_LSB       24
`define RX_SPACE_MSB      26
`define RX_INIT_FUNC_CODE 32'h3900_0000
`define RX_INIT_ADDR_TYPE 32'h3100_0000

// Sticky status bits
`define IST_ENTRY         0
`define IST_SUPPRESSED    1
`define IST_WIDTH         2

`endif

// [logic/hdlc_chan_pkg.sv]
// Types shared by the channel parameter bank
package hdlc_chan_pkg;
  typedef enum logic [0:0] {
    VARIANT_FUNC_CODE = 1'b0,
    VARIANT_ADDR_TYPE = 1'b1
  } rx_variant_e;
  typedef logic [15:0] event_word_t;
  typedef logic [31:0] rx_state_t;
  typedef logic [4:0]  chan_num_t;
endpackage

// [logic/hdlc_channel_event_mask_rx_state.sv]
// Per-channel event enable and receive state bank of a multichannel HDLC controller
//
// Overview of operation
// - Each event owns a fixed enable bit
// - Disabled event: no request, no table entry
// - Enabled event: request raised and entry written
// - Entry holds valid, wrap, channel, event flags
// - High byte gives qualifier, endianness; fixed bits
// - Endianness bit: 0 little, 1 big
// - Function-code variant: four-bit code bits 4-7
// - Address-type variant: bit 4 zero, type 5-7
// - Bit 0 is most significant; positions mirrored
`timescale 1ns/1ps
`include "hdlc_chan_regs.svh"

module hdlc_channel_event_mask_rx_state #(
  parameter int                         NUM_CHANNELS = 32,
  parameter hdlc_chan_pkg::rx_variant_e VARIANT      = hdlc_chan_pkg::VARIANT_FUNC_CODE
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       ev_strobe,
  input  wire hdlc_chan_pkg::chan_num_t   ev_chan,
  input  wire hdlc_chan_pkg::event_word_t ev_flags,
  input  wire logic                       ev_wrap,
  output logic                            entry_strobe,
  output hdlc_chan_pkg::event_word_t      entry_word,
  output hdlc_chan_pkg::event_word_t      event_req,
  output logic                            irq,
  input  wire hdlc_chan_pkg::chan_num_t   dma_chan,
  output logic                            rx_big_endian,
  output logic      [3:0]                 rx_cycle_class,
  output logic      [2:0]                 rx_bus_space
);
  import hdlc_chan_pkg::*;

  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 32) begin : g_bad_channels
    $error("NUM_CHANNELS must lie between 1 and 32");
  end

  // Guards the header: the stored mask must cover exactly the eight event positions
  localparam logic [15:0] EV_POS_OR = 16'(
    (1 << `EV_LINE_ACTIVE) | (1 << `EV_QUIET_LINE) | (1 << `EV_OVERSIZE_FRAME) | (1 << `EV_TX_STARVED) |
    (1 << `EV_RX_FRAME) | (1 << `EV_NO_BUFFER) | (1 << `EV_TX_BUFFER) | (1 << `EV_RX_BUFFER));
  if (EV_POS_OR != `EV_DEFINED_MASK) begin : g_bad_mask
    $error("Event mask does not match the event positions");
  end

  // Sticky bits are wired below as two literal lanes
  if (`IST_WIDTH != 2) begin : g_bad_status
    $error("Status layout expects two sticky bits");
  end

  localparam logic [5:0]  CH_LIMIT  = 6'(NUM_CHANNELS);
  localparam logic        AT_MODE   = (VARIANT == VARIANT_ADDR_TYPE);
  localparam rx_state_t   RX_RESET  = AT_MODE ? `RX_INIT_ADDR_TYPE : `RX_INIT_FUNC_CODE;
  localparam logic [2:0]  SIZE_WORD = 3'h2;

  event_word_t ev_en [NUM_CHANNELS];
  rx_state_t   rx_st [NUM_CHANNELS];
  logic [`IST_WIDTH-1:0] irq_status;
  logic [`IST_WIDTH-1:0] irq_en;
  logic        dp_write;
  logic [11:0] dp_addr;

  // Address phase
  wire logic addr_ok  = hsel & hready & htrans[1];
  wire logic rd_take  = addr_ok & ~hwrite;
  // Narrow writes are ignored: every register is one whole word
  wire logic wr_take  = addr_ok & hwrite & (hsize == SIZE_WORD);

  // Write address kept for the data phase, when hwdata arrives
  wire logic [11:0] next_dp_addr = wr_take ? haddr[11:0] : dp_addr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
    end else begin
      dp_write <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr <= 12'h000;
    end else begin
      dp_addr <= next_dp_addr;
    end
  end

  // Zero wait states, always OKAY
  // Kept as flops so every output leaves a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Write decode in the data phase
  wire chan_num_t wr_ch      = dp_addr[7:3];
  wire logic      wr_in_chan = (dp_addr[11:8] == `CHAN_REGION_TOP) && ({1'b0, wr_ch} < CH_LIMIT);
  wire logic      wr_en_hit  = dp_write & wr_in_chan & (dp_addr[2] == `EVENT_ENABLE_OFS);
  wire logic      wr_rx_hit  = dp_write & wr_in_chan & (dp_addr[2] == `RX_STATE_OFS);
  wire logic      wr_clr_hit = dp_write & (dp_addr == `IRQ_CLEAR_ADDR);
  wire logic      wr_ien_hit = dp_write & (dp_addr == `IRQ_ENABLE_ADDR);

  // Undefined positions are stored as zero, whatever software sends
  wire event_word_t next_ev_en = hwdata[15:0] & `EV_DEFINED_MASK;

  // Fixed bits of the high byte are forced, so a careless load cannot break them
  wire rx_state_t next_rx_st = {
    2'b00,
    1'b1,
    hwdata[`RX_BIG_ENDIAN_BIT],
    AT_MODE ? 1'b0 : hwdata[`RX_CODE_MSB],
    hwdata[`RX_SPACE_MSB:0]
  };

  // One register pair per channel; the decode above is shared by all of them
  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    wire logic this_ch = (wr_ch == 5'(c));
    wire logic en_here = wr_en_hit & this_ch;
    wire logic rx_here = wr_rx_hit & this_ch;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ev_en[c] <= `EV_ENABLE_RESET;
      end else if (en_here) begin
        ev_en[c] <= next_ev_en;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rx_st[c] <= RX_RESET;
      end else if (rx_here) begin
        rx_st[c] <= next_rx_st;
      end
    end
  end

  // Read decode in the address phase; data stands in the data phase
  wire chan_num_t rd_ch      = haddr[7:3];
  wire logic      rd_in_chan = (haddr[11:8] == `CHAN_REGION_TOP) && ({1'b0, rd_ch} < CH_LIMIT);
  wire rx_state_t rd_chan_w  = (haddr[2] == `RX_STATE_OFS) ? rx_st[rd_ch] : {16'h0000, ev_en[rd_ch]};
  wire logic      rd_status  = (haddr[11:0] == `IRQ_STATUS_ADDR);
  wire logic      rd_ienable = (haddr[11:0] == `IRQ_ENABLE_ADDR);
  wire logic [31:0] rd_status_w  = {30'h0000_0000, irq_status};
  wire logic [31:0] rd_ienable_w = {30'h0000_0000, irq_en};
  wire logic [31:0] rd_word  =
    rd_in_chan ? rd_chan_w :
    rd_status  ? rd_status_w :
    rd_ienable ? rd_ienable_w :
    32'h0000_0000;
  // Data stands only in its own data phase; an idle bus reads zero
  wire logic [31:0] next_hrdata = rd_take ? rd_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // Event path: one AND per event of the addressed channel
  wire logic        ev_ch_ok  = ({1'b0, ev_chan} < CH_LIMIT);
  wire event_word_t ev_sel_en = ev_ch_ok ? ev_en[ev_chan] : 16'h0000;
  wire event_word_t ev_defd   = ev_flags & `EV_DEFINED_MASK;
  wire event_word_t ev_pass   = ev_defd & ev_sel_en;
  wire event_word_t ev_block  = ev_defd & ~ev_sel_en;
  wire logic        ev_any    = ev_strobe & (|ev_pass);
  wire logic        ev_supp   = ev_strobe & (|ev_block);

  // Entry layout, least significant bit first: events 5:0, channel 10:6, reserved 11, events 13:12, wrap, valid
  wire event_word_t next_entry = {
    1'b1,
    ev_wrap,
    ev_pass[`EV_LINE_ACTIVE:`EV_QUIET_LINE],
    1'b0,
    ev_chan,
    ev_pass[`EV_OVERSIZE_FRAME:`EV_RX_BUFFER]
  };

  // Entry and request leave on one edge, so the table never disagrees with the requests
  wire logic        next_entry_strobe = ev_any;
  wire event_word_t next_entry_word   = ev_any ? next_entry : 16'h0000;
  wire event_word_t next_event_req    = ev_strobe ? ev_pass : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_strobe <= 1'b0;
    end else begin
      entry_strobe <= next_entry_strobe;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_word <= 16'h0000;
    end else begin
      entry_word <= next_entry_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_req <= 16'h0000;
    end else begin
      event_req <= next_event_req;
    end
  end

  // Sticky status: a set in the clearing cycle survives
  wire logic [`IST_WIDTH-1:0] ist_set  = {ev_supp, ev_any};
  wire logic [`IST_WIDTH-1:0] ist_clr  = wr_clr_hit ? hwdata[`IST_WIDTH-1:0] : 2'b00;
  wire logic [`IST_WIDTH-1:0] next_ist = (irq_status & ~ist_clr) | ist_set;
  wire logic [`IST_WIDTH-1:0] next_ien = wr_ien_hit ? hwdata[`IST_WIDTH-1:0] : irq_en;

  // Registered from the next values so irq moves on the same edge as status
  wire logic next_irq = |(next_ist & next_ien);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 2'b00;
    end else begin
      irq_status <= next_ist;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en <= 2'b00;
    end else begin
      irq_en <= next_ien;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Receive DMA qualifier of the channel the DMA engine is serving
  wire logic      dma_ch_ok = ({1'b0, dma_chan} < CH_LIMIT);
  wire rx_state_t dma_st    = dma_ch_ok ? rx_st[dma_chan] : RX_RESET;

  // Unused qualifier field reads zero in each variant
  wire logic       next_big_endian  = dma_st[`RX_BIG_ENDIAN_BIT];
  wire logic [3:0] next_cycle_class = AT_MODE ? 4'h0 : dma_st[`RX_CODE_MSB:`RX_CODE_LSB];
  wire logic [2:0] next_bus_space   = AT_MODE ? dma_st[`RX_SPACE_MSB:`RX_CODE_LSB] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_big_endian <= 1'b0;
    end else begin
      rx_big_endian <= next_big_endian;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cycle_class <= 4'h0;
    end else begin
      rx_cycle_class <= next_cycle_class;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_bus_space <= 3'h0;
    end else begin
      rx_bus_space <= next_bus_space;
    end
  end
endmodule

// [verification/chan_bank_checker.sv]
// Assertion checker for the channel event and receive state bank
`timescale 1ns/1ps
module chan_bank_checker #(
  parameter int                         NUM_CHANNELS = 32,
  parameter hdlc_chan_pkg::rx_variant_e VARIANT      = hdlc_chan_pkg::VARIANT_FUNC_CODE
) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       ev_strobe,
  input wire hdlc_chan_pkg::chan_num_t   ev_chan,
  input wire hdlc_chan_pkg::event_word_t ev_flags,
  input wire logic                       ev_wrap,
  input wire logic                       entry_strobe,
  input wire hdlc_chan_pkg::event_word_t entry_word,
  input wire hdlc_chan_pkg::event_word_t event_req,
  input wire logic [3:0]                 rx_cycle_class,
  input wire logic [2:0]                 rx_bus_space
);
  import hdlc_chan_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence ev_taken;
    ev_strobe;
  endsequence
  chk_no_stray_req:
    assert property (!$past(ev_strobe) |-> !entry_strobe && event_req == 16'h0000) else $error("stray request");
  chk_req_subset:
    assert property (ev_taken |=> (event_req & ~($past(ev_flags) & 16'h303f)) == 16'h0000)
    else $error("request not enabled by flags");
  chk_undef_quiet:
    assert property (ev_taken ##0 (ev_flags & 16'h303f) == 16'h0000 |=> !entry_strobe) else $error("undefined entry");
  chk_entry_with_req:
    assert property (entry_strobe == (event_req != 16'h0000)) else $error("entry and request disagree");
  chk_entry_header:
    assert property (entry_strobe |-> entry_word[15:14] == {1'b1, $past(ev_wrap)} && entry_word[10:6] == $past(ev_chan))
    else $error("entry header wrong");
  chk_entry_flags:
    assert property (entry_strobe |-> {entry_word[13:12], entry_word[5:0]} == {event_req[13:12], event_req[5:0]})
    else $error("entry flags wrong");
  chk_entry_quiet:
    assert property (!entry_strobe |-> entry_word == 16'h0000) else $error("entry word without strobe");
  chk_variant_zero:
    assert property ((VARIANT == VARIANT_FUNC_CODE) ? rx_bus_space == 3'h0 : rx_cycle_class == 4'h0)
    else $error("unused qualifier field not zero");
endmodule
bind hdlc_channel_event_mask_rx_state chan_bank_checker #(.NUM_CHANNELS(NUM_CHANNELS), .VARIANT(VARIANT)) u_chk (
  .hclk, .hresetn, .ev_strobe, .ev_chan, .ev_flags, .ev_wrap, .entry_strobe, .entry_word, .event_req,
  .rx_cycle_class, .rx_bus_space);

// [verification/tb_top.sv]
// Self-checking bench for the channel event and receive state bank
`timescale 1ns/1ps
module tb_top;
  import hdlc_chan_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, ev_strobe, ev_wrap, hreadyout, hresp, entry_strobe, irq, rx_big_endian;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, rx_bus_space;
  logic [3:0]  rx_cycle_class;
  chan_num_t   ev_chan, dma_chan;
  event_word_t ev_flags, entry_word, event_req;
  int          errors, n_checks, cyc;
  logic [31:0] hrdata_at, rdv_at;
  logic        hresp_at, rx_big_endian_at;
  logic [3:0]  rx_cycle_class_at;
  logic [2:0]  rx_bus_space_at;
  hdlc_channel_event_mask_rx_state dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .ev_strobe, .ev_chan, .ev_flags, .ev_wrap, .entry_strobe, .entry_word, .event_req, .irq, .dma_chan,
    .rx_big_endian, .rx_cycle_class, .rx_bus_space);
  // Second instance covers the address-type variant on the same bus
  hdlc_channel_event_mask_rx_state #(.VARIANT(VARIANT_ADDR_TYPE)) dut_at (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata(hrdata_at),
    .hreadyout(), .hresp(hresp_at), .ev_strobe, .ev_chan, .ev_flags, .ev_wrap, .entry_strobe(), .entry_word(),
    .event_req(), .irq(), .dma_chan, .rx_big_endian(rx_big_endian_at), .rx_cycle_class(rx_cycle_class_at),
    .rx_bus_space(rx_bus_space_at));
  always #10 hclk = ~hclk;
  task automatic print_verdict;
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    // Whole run needs under a hundred cycles
    if (cyc == 3000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic addr_ph(input logic [31:0] a, input logic w);
    @(posedge hclk);
    {hsel, hwrite, htrans, hsize, haddr} <= {1'b1, w, 2'h2, 3'h2, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a);
    addr_ph(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    rdv_at = hrdata_at;
    cmp("hresp", 32'h0000_0000, {hresp_at, hresp});
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    cmp($sformatf("read %h", a), exp, rdv);
  endtask
  task automatic chk_rd_at(input logic [31:0] a, input logic [31:0] exp);
    rd(a);
    cmp($sformatf("read_at %h", a), exp, rdv_at);
  endtask
  task automatic ev(input chan_num_t c, input event_word_t f, input logic w, input logic [15:0] ew,
                    input logic [15:0] er);
    @(posedge hclk);
    {ev_strobe, ev_chan, ev_flags, ev_wrap} <= {1'b1, c, f, w};
    @(posedge hclk);
    ev_strobe <= 1'b0;
    #1;
    cmp("entry_word", ew, entry_word);
    cmp("event_req", er, event_req);
    cmp("entry_strobe", ew != 16'h0000, entry_strobe);
  endtask
  // Packs endianness, class and space as one byte
  task automatic qual(input chan_num_t c, input logic [7:0] exp, input logic [7:0] exp_at);
    @(posedge hclk);
    dma_chan <= c;
    repeat (2) @(posedge hclk);
    #1 cmp("rx_qualifier", exp, {rx_big_endian, rx_cycle_class, rx_bus_space});
    cmp("rx_qualifier_at", exp_at, {rx_big_endian_at, rx_cycle_class_at, rx_bus_space_at});
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, ev_strobe, ev_wrap, htrans, hsize} = '0;
    {haddr, hwdata, ev_chan, ev_flags, dma_chan} = '0;
    {errors, n_checks, cyc} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    qual(5'h00, 8'hc8, 8'h81);
    chk_rd(32'h0000_0000, 32'h0000_0000);
    chk_rd(32'h0000_001c, 32'h3900_0000);
    chk_rd_at(32'h0000_001c, 32'h3100_0000);
    wr(32'h0000_0018, 32'hffff_ffff);
    chk_rd(32'h0000_0018, 32'h0000_303f);
    wr(32'h0000_001c, 32'h0700_0000);
    chk_rd(32'h0000_001c, 32'h2700_0000);
    wr(32'h0000_0014, 32'h0f00_0000);
    chk_rd(32'h0000_0014, 32'h2f00_0000);
    chk_rd_at(32'h0000_0014, 32'h2700_0000);
    qual(5'h03, 8'h38, 8'h07);
    ev(5'h03, 16'hffff, 1'b1, 16'hf0ff, 16'h303f);
    ev(5'h03, 16'hcfc0, 1'b1, 16'h0000, 16'h0000);
    ev(5'h01, 16'h0008, 1'b0, 16'h0000, 16'h0000);
    wr(32'h0000_0008, 32'h0000_0001);
    ev(5'h01, 16'h0009, 1'b0, 16'h8041, 16'h0001);
    chk_rd(32'h0000_0100, 32'h0000_0003);
    #1 cmp("irq", 1'b0, irq);
    wr(32'h0000_0108, 32'h0000_0002);
    #1 cmp("irq", 1'b1, irq);
    chk_rd(32'h0000_0108, 32'h0000_0002);
    wr(32'h0000_0104, 32'h0000_0002);
    #1 cmp("irq", 1'b0, irq);
    chk_rd(32'h0000_0100, 32'h0000_0001);
    chk_rd(32'h0000_0104, 32'h0000_0000);
    chk_rd(32'h0000_0200, 32'h0000_0000);
    print_verdict;
  end
endmodule
